// ---- design/acld_pkg.sv ----
`default_nettype none
package acld_pkg;

  // register offsets on the byte-wide control port
  localparam logic [7:0] ACLD_OFS_CTRL_A = 8'h15;
  localparam logic [7:0] ACLD_OFS_CTRL_B = 8'h16;
  localparam logic [7:0] ACLD_OFS_CH1_RES = 8'h17;
  localparam logic [7:0] ACLD_OFS_CH2_RES = 8'h18;
  localparam logic [7:0] ACLD_OFS_ANGLE_HI = 8'h1b;
  localparam logic [7:0] ACLD_OFS_ANGLE_LO = 8'h1c;
  localparam logic [7:0] ACLD_OFS_STIM_HI = 8'h1d;
  localparam logic [7:0] ACLD_OFS_STIM_LO = 8'h1e;
  localparam logic [7:0] ACLD_OFS_MISC = 8'h21;
  localparam logic [7:0] ACLD_OFS_CLIP = 8'h22;

  // field positions in ac_diag_ctrl_a
  localparam int ACLD_GAIN1_BIT = 7;
  localparam int ACLD_GAIN2_BIT = 6;
  localparam int ACLD_ON1_BIT = 3;
  localparam int ACLD_ON2_BIT = 2;
  // field positions in ac_diag_ctrl_b
  localparam int ACLD_LOOP_BIT = 7;
  localparam int ACLD_DUR_BIT = 4;
  localparam int ACLD_CUR_MSB = 3;
  localparam int ACLD_CUR_LSB = 2;
  // field positions in misc_control_three
  localparam int ACLD_CLEAR_BIT = 7;
  localparam int ACLD_PBSRC_BIT = 6;
  localparam int ACLD_RESUME_BIT = 3;
  // clip_detect_control keeps its three low bits
  localparam int ACLD_CLIP_MSB = 2;

  // writable bits; bits outside the mask read as zero
  localparam logic [7:0] ACLD_CTRL_A_MASK = 8'hff;
  localparam logic [7:0] ACLD_CTRL_B_MASK = 8'hff;
  localparam logic [7:0] ACLD_MISC_MASK = 8'hf8;
  localparam logic [7:0] ACLD_CLIP_MASK = 8'h07;

  localparam logic [7:0] ACLD_CTRL_A_RST = 8'h00;
  localparam logic [7:0] ACLD_CTRL_B_RST = 8'h00;
  localparam logic [7:0] ACLD_MISC_RST = 8'h00;
  localparam logic [7:0] ACLD_CLIP_RST = 8'h01;
  localparam logic [7:0] ACLD_RES_RST = 8'h00;
  localparam logic [7:0] ACLD_RD_NONE = 8'h00;

  // field encodings
  localparam logic ACLD_GAIN_X1 = 1'b0;
  localparam logic ACLD_GAIN_X4 = 1'b1;
  localparam logic ACLD_DUR_32 = 1'b0;
  localparam logic ACLD_DUR_64 = 1'b1;
  localparam logic [1:0] ACLD_CUR_10MA = 2'h0;
  localparam logic [1:0] ACLD_CUR_19MA = 2'h1;

  localparam int ACLD_CHANNELS = 2;

  // one access on the control port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acld_req_t;

  // decoded settings driven to the analogue and protection logic
  typedef struct packed {
    logic [ACLD_CHANNELS-1:0] gain;
    logic [ACLD_CHANNELS-1:0] diag_on;
    logic loop_return;
    logic duration_sel;
    logic [1:0] test_current_sel;
    logic current_code_bad;
    logic parallel_bridge_source_sel;
    logic thermal_stop_self_resume;
    logic [2:0] clip_ctrl;
  } acld_cfg_t;

  // one finished measurement from the analogue side
  typedef struct packed {
    logic [ACLD_CHANNELS-1:0][7:0] channel_load_result;
    logic [15:0] angle_result;
    logic [15:0] stimulus_result;
  } acld_meas_t;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] misc;
    logic [7:0] clip;
    logic [7:0] rdata;
    logic rvalid;
    logic fault_clear;
    acld_cfg_t cfg;
  } acld_main_st_t;

endpackage : acld_pkg
`default_nettype wire

// ---- design/acld_regs.sv ----
`default_nettype none
module acld_regs (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire acld_pkg::acld_req_t req_i,
  input wire logic meas_valid_i,
  input wire acld_pkg::acld_meas_t meas_i,
  input wire logic thermal_hot_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output acld_pkg::acld_cfg_t cfg_o,
  output logic fault_clear_o,
  output logic thermal_stop_o
);

  acld_pkg::acld_main_st_t st;
  acld_pkg::acld_main_st_t next_st;
  // nets, since each hold instance drives its own slice
  wire acld_pkg::acld_meas_t res;
  wire logic [acld_pkg::ACLD_CHANNELS-1:0] chan_load;

  // per-channel impedance codes pass through untouched; the ohm scale
  // belongs to the analogue side and its current gain/duration settings
  for (genvar ch = 0; ch < acld_pkg::ACLD_CHANNELS; ch++) begin : g_chan
    assign chan_load[ch] = meas_valid_i & st.cfg.diag_on[ch];
    acld_result_hold #(
      .WIDTH(8)
    ) u_chan_res (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .load_i(chan_load[ch]),
      .d_i(meas_i.channel_load_result[ch]),
      .q_o(res.channel_load_result[ch])
    );
  end

  // both 16-bit results load in one edge so the two bytes always match
  acld_result_hold #(
    .WIDTH(16)
  ) u_angle_res (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .load_i(meas_valid_i),
    .d_i(meas_i.angle_result),
    .q_o(res.angle_result)
  );

  acld_result_hold #(
    .WIDTH(16)
  ) u_stim_res (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .load_i(meas_valid_i),
    .d_i(meas_i.stimulus_result),
    .q_o(res.stimulus_result)
  );

  acld_thermal_ctl u_thermal (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .hot_i(thermal_hot_i),
    .self_resume_i(st.cfg.thermal_stop_self_resume),
    .clear_i(st.fault_clear),
    .stop_o(thermal_stop_o)
  );

  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.fault_clear = 1'b0;

    if (req_i.wr) begin
      case (req_i.addr)
        acld_pkg::ACLD_OFS_CTRL_A: begin
          next_st.ctrl_a = req_i.wdata & acld_pkg::ACLD_CTRL_A_MASK;
        end
        acld_pkg::ACLD_OFS_CTRL_B: begin
          next_st.ctrl_b = req_i.wdata & acld_pkg::ACLD_CTRL_B_MASK;
        end
        acld_pkg::ACLD_OFS_MISC: begin
          next_st.misc = req_i.wdata & acld_pkg::ACLD_MISC_MASK;
          // one pulse per write of a one; the stored bit only reads back
          next_st.fault_clear = req_i.wdata[acld_pkg::ACLD_CLEAR_BIT];
        end
        acld_pkg::ACLD_OFS_CLIP: begin
          next_st.clip = req_i.wdata & acld_pkg::ACLD_CLIP_MASK;
        end
        default: begin
          // result offsets and unmapped offsets drop the write
          next_st.ctrl_a = st.ctrl_a;
        end
      endcase
    end

    if (req_i.rd) begin
      next_st.rvalid = 1'b1;
      case (req_i.addr)
        acld_pkg::ACLD_OFS_CTRL_A: next_st.rdata = st.ctrl_a;
        acld_pkg::ACLD_OFS_CTRL_B: next_st.rdata = st.ctrl_b;
        acld_pkg::ACLD_OFS_CH1_RES: begin
          next_st.rdata = res.channel_load_result[0];
        end
        acld_pkg::ACLD_OFS_CH2_RES: begin
          next_st.rdata = res.channel_load_result[1];
        end
        acld_pkg::ACLD_OFS_ANGLE_HI: begin
          next_st.rdata = res.angle_result[15:8];
        end
        acld_pkg::ACLD_OFS_ANGLE_LO: begin
          next_st.rdata = res.angle_result[7:0];
        end
        acld_pkg::ACLD_OFS_STIM_HI: begin
          next_st.rdata = res.stimulus_result[15:8];
        end
        acld_pkg::ACLD_OFS_STIM_LO: begin
          next_st.rdata = res.stimulus_result[7:0];
        end
        acld_pkg::ACLD_OFS_MISC: next_st.rdata = st.misc;
        acld_pkg::ACLD_OFS_CLIP: next_st.rdata = st.clip;
        default: next_st.rdata = acld_pkg::ACLD_RD_NONE;
      endcase
    end

    // decoded settings follow the register copies in the same edge
    next_st.cfg.gain[0] = next_st.ctrl_a[acld_pkg::ACLD_GAIN1_BIT];
    next_st.cfg.gain[1] = next_st.ctrl_a[acld_pkg::ACLD_GAIN2_BIT];
    next_st.cfg.diag_on[0] = next_st.ctrl_a[acld_pkg::ACLD_ON1_BIT];
    next_st.cfg.diag_on[1] = next_st.ctrl_a[acld_pkg::ACLD_ON2_BIT];
    next_st.cfg.loop_return =
      next_st.ctrl_b[acld_pkg::ACLD_LOOP_BIT];
    next_st.cfg.duration_sel =
      next_st.ctrl_b[acld_pkg::ACLD_DUR_BIT];
    next_st.cfg.test_current_sel =
      next_st.ctrl_b[acld_pkg::ACLD_CUR_MSB:acld_pkg::ACLD_CUR_LSB];
    // reserved current codes are kept but flagged, the analogue side
    // must not act on them
    next_st.cfg.current_code_bad =
      (next_st.cfg.test_current_sel != acld_pkg::ACLD_CUR_10MA) &&
      (next_st.cfg.test_current_sel != acld_pkg::ACLD_CUR_19MA);
    next_st.cfg.parallel_bridge_source_sel =
      next_st.misc[acld_pkg::ACLD_PBSRC_BIT];
    next_st.cfg.thermal_stop_self_resume =
      next_st.misc[acld_pkg::ACLD_RESUME_BIT];
    next_st.cfg.clip_ctrl = next_st.clip[acld_pkg::ACLD_CLIP_MSB:0];
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '0;
      st.ctrl_a <= acld_pkg::ACLD_CTRL_A_RST;
      st.ctrl_b <= acld_pkg::ACLD_CTRL_B_RST;
      st.misc <= acld_pkg::ACLD_MISC_RST;
      st.clip <= acld_pkg::ACLD_CLIP_RST;
      st.cfg.clip_ctrl <= acld_pkg::ACLD_CLIP_RST[acld_pkg::ACLD_CLIP_MSB:0];
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign rvalid_o = st.rvalid;
  assign cfg_o = st.cfg;
  assign fault_clear_o = st.fault_clear;

  // the scale fixed lives outside; these settings steer it
  logic [3:0] scale_sel;
  assign scale_sel = {st.cfg.gain[0], st.cfg.duration_sel,
                      st.cfg.test_current_sel};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  gain_store_a: assert property (
    req_i.wr && req_i.addr == acld_pkg::ACLD_OFS_CTRL_A |=>
      cfg_o.gain == {$past(req_i.wdata[6]), $past(req_i.wdata[7])})
    else $error("diagnostic gain bits not taken from write");

  diag_on_a: assert property (
    req_i.wr && req_i.addr == acld_pkg::ACLD_OFS_CTRL_A |=>
      cfg_o.diag_on == {$past(req_i.wdata[2]), $past(req_i.wdata[3])})
    else $error("diagnostic enable bits not taken from write");

  loop_store_a: assert property (
    !(req_i.wr && req_i.addr == acld_pkg::ACLD_OFS_CTRL_B) |=>
      $stable(cfg_o.loop_return))
    else $error("loopback changed without a write");

  current_sel_a: assert property (
    req_i.wr && req_i.addr == acld_pkg::ACLD_OFS_CTRL_B |=>
      cfg_o.test_current_sel == $past(req_i.wdata[3:2]) &&
      cfg_o.duration_sel == $past(req_i.wdata[4]) &&
      cfg_o.current_code_bad == $past(req_i.wdata[3]))
    else $error("duration or current select wrong");

  chan_read_a: assert property (
    req_i.rd && req_i.addr == acld_pkg::ACLD_OFS_CH2_RES |=>
      rvalid_o && rdata_o == $past(res.channel_load_result[1]))
    else $error("channel two result read wrong");

  angle_split_a: assert property (
    req_i.rd && req_i.addr == acld_pkg::ACLD_OFS_ANGLE_HI |=>
      rdata_o == $past(res.angle_result[15:8]))
    else $error("angle upper byte read wrong");

  stim_split_a: assert property (
    req_i.rd && req_i.addr == acld_pkg::ACLD_OFS_STIM_LO |=>
      rdata_o == $past(res.stimulus_result[7:0]))
    else $error("stimulus lower byte read wrong");

  clear_pulse_a: assert property (
    req_i.wr && req_i.addr == acld_pkg::ACLD_OFS_MISC && req_i.wdata[7] &&
      !thermal_hot_i ##1 !thermal_hot_i |=>
      !thermal_stop_o && !fault_clear_o)
    else $error("fault clear did not release thermal stop");

  pb_source_a: assert property (
    req_i.wr && req_i.addr == acld_pkg::ACLD_OFS_MISC |=>
      cfg_o.parallel_bridge_source_sel == $past(req_i.wdata[6]))
    else $error("parallel bridge source not taken");

  thermal_latch_a: assert property (
    thermal_stop_o && !cfg_o.thermal_stop_self_resume && !fault_clear_o
      |=> thermal_stop_o)
    else $error("latched thermal stop dropped without clear");

  result_ro_a: assert property (
    !meas_valid_i |=> $stable(res))
    else $error("result changed without a measurement");

  scale_hold_a: assert property (
    !(req_i.wr && (req_i.addr == acld_pkg::ACLD_OFS_CTRL_A ||
      req_i.addr == acld_pkg::ACLD_OFS_CTRL_B)) |=> $stable(scale_sel))
    else $error("scale settings changed without a write");

  chan_load_a: assert property (
    meas_valid_i && cfg_o.diag_on[0] |=>
      res.channel_load_result[0] == $past(meas_i.channel_load_result[0]))
    else $error("channel one result not loaded");

  chan_skip_a: assert property (
    meas_valid_i && !cfg_o.diag_on[1] |=>
      $stable(res.channel_load_result[1]))
    else $error("disabled channel result moved");

  angle_low_a: assert property (
    req_i.rd && req_i.addr == acld_pkg::ACLD_OFS_ANGLE_LO |=>
      rdata_o == $past(res.angle_result[7:0]))
    else $error("angle lower byte read wrong");

  stim_high_a: assert property (
    req_i.rd && req_i.addr == acld_pkg::ACLD_OFS_STIM_HI |=>
      rdata_o == $past(res.stimulus_result[15:8]))
    else $error("stimulus upper byte read wrong");

  cover_meas_c: cover property (
    meas_valid_i ##1 req_i.rd && req_i.addr == acld_pkg::ACLD_OFS_ANGLE_LO);
  cover_resume_c: cover property (
    thermal_stop_o && cfg_o.thermal_stop_self_resume ##1 !thermal_stop_o);
  cover_clear_c: cover property (fault_clear_o ##[1:3] !thermal_stop_o);
  cover_bad_cur_c: cover property (cfg_o.current_code_bad);

endmodule : acld_regs
`default_nettype wire

// ---- design/acld_result_hold.sv ----
`default_nettype none
module acld_result_hold #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] value;
  } acld_hold_st_t;

  acld_hold_st_t st;
  acld_hold_st_t next_st;

  // only a finished measurement moves the value; host writes never reach it
  always_comb begin
    next_st = st;
    if (load_i) begin
      next_st.value = d_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.value;

endmodule : acld_result_hold
`default_nettype wire

// ---- design/acld_thermal_ctl.sv ----
`default_nettype none
module acld_thermal_ctl (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic hot_i,
  input wire logic self_resume_i,
  input wire logic clear_i,
  output logic stop_o
);

  typedef struct packed {
    logic stop;
  } acld_therm_st_t;

  acld_therm_st_t st;
  acld_therm_st_t next_st;

  // an ongoing overtemperature beats a clear, so the stop never drops hot
  always_comb begin
    next_st = st;
    if (hot_i) begin
      next_st.stop = 1'b1;
    end else if (self_resume_i) begin
      next_st.stop = 1'b0;
    end else if (clear_i) begin
      next_st.stop = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign stop_o = st.stop;

endmodule : acld_thermal_ctl
`default_nettype wire

// ---- dv/acld_host_model.sv ----
`default_nettype none
module acld_host_model (
  input wire logic clk_i,
  output acld_pkg::acld_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req_o = '0;

  // caller sits at a falling edge; the request holds across the next rise
  task automatic access(input logic w, input logic r, input logic [7:0] a,
                        input logic [7:0] d);
    req_o <= '{addr: a, wdata: d, wr: w, rd: r};
    @(negedge clk_i);
  endtask

  // a released bus shows the inverse of the last value, never a stale copy
  task automatic idle();
    req_o <= '{addr: ~req_o.addr, wdata: ~req_o.wdata, wr: 1'b0, rd: 1'b0};
  endtask
endmodule : acld_host_model
`default_nettype wire

// ---- dv/tb.sv ----
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic meas_valid_i = 1'b0;
  logic thermal_hot_i = 1'b0;
  acld_pkg::acld_meas_t meas_i = '0;
  acld_pkg::acld_req_t req;
  acld_pkg::acld_cfg_t cfg_o;
  logic [7:0] rdata_o;
  logic rvalid_o, fault_clear_o, thermal_stop_o;
  int fails = 0;
  int samples_checked = 0;
  logic [7:0] mirror [256];
  logic [7:0] expq [$];
  logic [7:0] regs [11] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h1b, 8'h1c,
                            8'h1d, 8'h1e, 8'h21, 8'h22, 8'h19};

  always #2.5 clk_i = ~clk_i;

  acld_host_model host (.clk_i(clk_i), .req_o(req));

  acld_regs DUT (.clk_i(clk_i), .srst_i(srst_i), .req_i(req),
    .meas_valid_i(meas_valid_i), .meas_i(meas_i),
    .thermal_hot_i(thermal_hot_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .cfg_o(cfg_o), .fault_clear_o(fault_clear_o),
    .thermal_stop_o(thermal_stop_o));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      8'h15, 8'h16: return 8'hff;
      8'h21: return 8'hf8;
      8'h22: return 8'h07;
      default: return 8'h00;
    endcase
  endfunction

  function automatic acld_pkg::acld_cfg_t exp_cfg();
    acld_pkg::acld_cfg_t e;
    e = '0;
    e.gain = {mirror[8'h15][6], mirror[8'h15][7]};
    e.diag_on = {mirror[8'h15][2], mirror[8'h15][3]};
    e.loop_return = mirror[8'h16][7];
    e.duration_sel = mirror[8'h16][4];
    e.test_current_sel = mirror[8'h16][3:2];
    e.current_code_bad = mirror[8'h16][3];
    e.parallel_bridge_source_sel = mirror[8'h21][6];
    e.thermal_stop_self_resume = mirror[8'h21][3];
    e.clip_ctrl = mirror[8'h22][2:0];
    return e;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (wmask(a) != 8'h00) mirror[a] = d & wmask(a);
    host.access(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    expq.push_back(mirror[a]);
    host.access(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic measure(input acld_pkg::acld_meas_t m);
    meas_valid_i <= 1'b1;
    meas_i <= m;
    if (mirror[8'h15][3]) mirror[8'h17] = m.channel_load_result[0];
    if (mirror[8'h15][2]) mirror[8'h18] = m.channel_load_result[1];
    {mirror[8'h1b], mirror[8'h1c]} = m.angle_result;
    {mirror[8'h1d], mirror[8'h1e]} = m.stimulus_result;
    @(negedge clk_i);
    meas_valid_i <= 1'b0;
  endtask

  // read data is one cycle after the request, so settled by the next fall
  always @(negedge clk_i) begin
    if (rvalid_o === 1'b1) begin
      if (expq.size() == 0) begin
        fails++;
        $display("Error at %0t: read data with none pending", $time);
      end else begin
        chk(rdata_o, expq.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    $display("Error at %0t: run did not complete", $time);
    tally_and_finish();
  end

  initial begin
    logic [31:0] r;
    logic [63:0] r64;
    r = $urandom(72);
    foreach (mirror[i]) mirror[i] = 8'h00;
    mirror[8'h22] = 8'h01;
    repeat (8) @(negedge clk_i);
    srst_i <= 1'b0;
    chk(cfg_o, exp_cfg());
    foreach (regs[i]) rd(regs[i]);
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      wr(8'h15, r[7:0]);
      wr(8'h16, {r[15:12], i[1:0], r[9:8]});
      wr(8'h21, r[23:16]);
      wr(8'h22, r[31:24] & 8'hfb);
      host.idle();
      @(negedge clk_i);
      chk(cfg_o, exp_cfg());
      r64 = {$urandom, $urandom};
      measure(r64[47:0]);
      foreach (regs[j]) wr(regs[j] ^ 8'h00, r64[55:48]);
      foreach (regs[j]) rd(regs[j]);
      host.idle();
      @(negedge clk_i);
    end
    wr(8'h21, 8'h00);
    host.idle();
    thermal_hot_i <= 1'b1;
    @(negedge clk_i);
    chk(thermal_stop_o, 1);
    thermal_hot_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk(thermal_stop_o, 1);
    wr(8'h21, 8'h80);
    chk(fault_clear_o, 1);
    host.idle();
    @(negedge clk_i);
    chk(fault_clear_o, 0);
    chk(thermal_stop_o, 0);
    rd(8'h21);
    wr(8'h21, 8'h08);
    host.idle();
    thermal_hot_i <= 1'b1;
    @(negedge clk_i);
    chk(thermal_stop_o, 1);
    thermal_hot_i <= 1'b0;
    @(negedge clk_i);
    chk(thermal_stop_o, 0);
    repeat (3) @(negedge clk_i);
    chk(expq.size(), 0);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
